// *** ppc_map.svh ***
// timing constants and fixed values for the port pin control block
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH
`define PPC_CLK_MHZ 25
`define PPC_DEGLITCH_MIN_NS 1000
`define PPC_DEGLITCH_CYC ((`PPC_DEGLITCH_MIN_NS * `PPC_CLK_MHZ + 999) / 1000)
`define PPC_BACKOFF_MS 400
`define PPC_BACKOFF_CYC (`PPC_BACKOFF_MS * 1000 * `PPC_CLK_MHZ)
`define PPC_PROBE_MS 1
`define PPC_PROBE_CYC (`PPC_PROBE_MS * 1000 * `PPC_CLK_MHZ)
`define PPC_FSD_SLOT_US 5
`define PPC_FSD_SLOT_CYC (`PPC_FSD_SLOT_US * `PPC_CLK_MHZ)
`define PPC_FSD_PULSES 3
`define PPC_FSD_SLOTS 4
`define PPC_STRAP_SETTLE 2'h3
`define PPC_PORT_ALL_OFF 8'h00
`endif

// *** ppc_pkg.sv ***
// types for the port pin control block
package ppc_pkg;
    typedef enum logic [4:0] {
        PPC_DET_IDLE = 5'h01,
        PPC_DET_BACKOFF = 5'h02,
        PPC_DET_PROBE_LO = 5'h04,
        PPC_DET_PROBE_HI = 5'h08,
        PPC_DET_DONE = 5'h10
    } ppc_det_e;
endpackage

// *** ppc_deglitch.sv ***
// two-flop synchroniser followed by a stable-time deglitch filter
`include "ppc_map.svh"
module ppc_deglitch #(
    parameter int CYC = `PPC_DEGLITCH_CYC,
    parameter logic INIT = 1'b0
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic pin_in,
    output logic level_q
);
    logic s1_q;
    logic s2_q;
    logic [15:0] cnt_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= INIT;
            s2_q <= INIT;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 16'h0000;
            level_q <= INIT;
        end else if (s2_q == level_q) begin
            cnt_q <= 16'h0000;
        end else if (cnt_q >= 16'(CYC - 1)) begin
            cnt_q <= 16'h0000;
            level_q <= s2_q;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
endmodule

// *** ppc_top.sv ***
// pin-level control: interrupt, reset, fast shutdown, detection, gate drives
`include "ppc_map.svh"
module ppc_top #(
    parameter int NPORT = 8,
    parameter int BACKOFF_CYC = `PPC_BACKOFF_CYC,
    parameter int PROBE_CYC = `PPC_PROBE_CYC
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic por_b,
    input wire logic reset_pin_b,
    input wire logic fast_shutdown_in,
    input wire logic [2:0] shutdown_priority,
    input wire logic [23:0] port_priority,
    input wire logic [NPORT-1:0] port_on_req,
    input wire logic [NPORT-1:0] port_reset_cmd,
    input wire logic [NPORT-1:0] manual_shutdown,
    input wire logic [NPORT-1:0] overcurrent_timeout,
    input wire logic [NPORT-1:0] fast_overload,
    input wire logic supplies_ok,
    input wire logic [NPORT-1:0] port_voltage_high,
    input wire logic [NPORT-1:0] detect_req,
    input wire logic [NPORT-1:0] class_req,
    input wire logic [7:0] int_flags,
    input wire logic auto_strap_grounded,
    input wire logic serial_data_in_pin,
    input wire logic serial_data_drive_low,
    output logic int_pin_oe_b,
    output logic int_pin_out,
    output logic serial_data_out_pin_oe_b,
    output logic serial_data_out_pin_out,
    output logic serial_data_in_q,
    output logic [NPORT-1:0] port_gate_drive,
    output logic [NPORT-1:0] discharge_en,
    output logic [NPORT-1:0] probe_lo_en,
    output logic [NPORT-1:0] probe_hi_en,
    output logic [NPORT-1:0] detect_done,
    output logic [NPORT-1:0] class_active,
    output logic autonomous_en,
    output logic [NPORT-1:0] port_off_event
);
    logic rst_pin_level;
    logic fsd_level;
    logic fsd_level_d1_q;
    logic core_rst_b;
    logic sd_s1_q;
    logic sd_s2_q;
    logic [NPORT-1:0] gov_s1_q;
    logic [NPORT-1:0] gov_s2_q;
    logic [NPORT-1:0] fsd_kill_q;
    logic [NPORT-1:0] on_q;
    logic [1:0] pulse_cnt_q;
    logic [15:0] slot_q;
    logic strap_s1_q;
    logic strap_s2_q;
    logic [1:0] strap_cnt_q;
    logic fsd_rise;

    // reset pin deglitch runs on the internal power-on reset only
    ppc_deglitch #(.CYC(`PPC_DEGLITCH_CYC), .INIT(1'b1)) u_rst_dg (
        .mclk(mclk),
        .rst_b(por_b),
        .pin_in(reset_pin_b),
        .level_q(rst_pin_level)
    );
    assign core_rst_b = rst_b & por_b & rst_pin_level;

    ppc_deglitch #(.CYC(`PPC_DEGLITCH_CYC), .INIT(1'b0)) u_fsd_dg (
        .mclk(mclk),
        .rst_b(core_rst_b),
        .pin_in(fast_shutdown_in),
        .level_q(fsd_level)
    );

    function automatic logic [NPORT-1:0] prio_mask(input logic [23:0] pr,
                                                  input logic [1:0] thr);
        logic [NPORT-1:0] m;
        m = '0;
        for (int i = 0; i < NPORT; i++) begin
            m[i] = (pr[i*3 +: 3] >= {1'b0, thr});
        end
        return m;
    endfunction

    // a port goes off on a reset command or a decoded shutdown train
    function automatic logic [NPORT-1:0] off_mask(input logic [NPORT-1:0] cmd,
                                                 input logic [NPORT-1:0] kill);
        return cmd | kill;
    endfunction

    // edge detect on the filtered shutdown level; idle level is low
    always_ff @(posedge mclk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            fsd_level_d1_q <= 1'b0;
        end else begin
            fsd_level_d1_q <= fsd_level;
        end
    end
    assign fsd_rise = fsd_level & ~fsd_level_d1_q;

    // two-bit pulse count, held at three: pulses counted until the slot window runs out
    always_ff @(posedge mclk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            pulse_cnt_q <= 2'h0;
            slot_q <= 16'h0000;
        end else if (fsd_rise) begin
            if (pulse_cnt_q != 2'(`PPC_FSD_PULSES)) begin
                pulse_cnt_q <= pulse_cnt_q + 2'h1;
            end
            slot_q <= 16'(`PPC_FSD_SLOT_CYC * `PPC_FSD_SLOTS);
        end else if (slot_q != 16'h0000) begin
            slot_q <= slot_q - 16'h0001;
            if (slot_q == 16'h0001) begin
                pulse_cnt_q <= 2'h0;
            end
        end
    end

    // kill mask stands for one cycle when the window closes
    always_ff @(posedge mclk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            fsd_kill_q <= `PPC_PORT_ALL_OFF;
        end else if (slot_q == 16'h0001 && !fsd_rise) begin
            fsd_kill_q <= prio_mask(port_priority, pulse_cnt_q)
                | {NPORT{shutdown_priority == 3'h0}};
        end else begin
            fsd_kill_q <= `PPC_PORT_ALL_OFF;
        end
    end

    // port on state; fast shutdown takes the port-reset path
    always_ff @(posedge mclk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            on_q <= `PPC_PORT_ALL_OFF;
            port_off_event <= `PPC_PORT_ALL_OFF;
        end else begin
            port_off_event <= on_q & off_mask(port_reset_cmd, fsd_kill_q);
            on_q <= (on_q | port_on_req) & ~off_mask(port_reset_cmd, fsd_kill_q);
        end
    end

    always_ff @(posedge mclk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            gov_s1_q <= '0;
            gov_s2_q <= '0;
        end else begin
            gov_s1_q <= fast_overload;
            gov_s2_q <= gov_s1_q;
        end
    end

    always_ff @(posedge mclk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            port_gate_drive <= `PPC_PORT_ALL_OFF;
        end else begin
            port_gate_drive <= on_q & {NPORT{supplies_ok}}
                & ~overcurrent_timeout
                & ~manual_shutdown
                & ~gov_s2_q & ~off_mask(port_reset_cmd, fsd_kill_q);
        end
    end

    // per-port detection engine
    genvar g;
    generate
        for (g = 0; g < NPORT; g++) begin : gen_det
            ppc_pkg::ppc_det_e st_q;
            logic [31:0] tmr_q;
            always_ff @(posedge mclk or negedge core_rst_b) begin
                if (!core_rst_b) begin
                    st_q <= ppc_pkg::PPC_DET_IDLE;
                    tmr_q <= 32'h0000_0000;
                end else begin
                    case (st_q)
                        ppc_pkg::PPC_DET_IDLE: begin
                            if (detect_req[g] && !on_q[g]) begin
                                if (port_voltage_high[g]) begin
                                    st_q <= ppc_pkg::PPC_DET_BACKOFF;
                                    tmr_q <= 32'(BACKOFF_CYC - 1);
                                end else begin
                                    st_q <= ppc_pkg::PPC_DET_PROBE_LO;
                                    tmr_q <= 32'(PROBE_CYC - 1);
                                end
                            end
                        end
                        ppc_pkg::PPC_DET_BACKOFF: begin
                            if (tmr_q == 32'h0000_0000) begin
                                st_q <= ppc_pkg::PPC_DET_PROBE_LO;
                                tmr_q <= 32'(PROBE_CYC - 1);
                            end else begin
                                tmr_q <= tmr_q - 32'h0000_0001;
                            end
                        end
                        ppc_pkg::PPC_DET_PROBE_LO: begin
                            if (tmr_q == 32'h0000_0000) begin
                                st_q <= ppc_pkg::PPC_DET_PROBE_HI;
                                tmr_q <= 32'(PROBE_CYC - 1);
                            end else begin
                                tmr_q <= tmr_q - 32'h0000_0001;
                            end
                        end
                        ppc_pkg::PPC_DET_PROBE_HI: begin
                            if (tmr_q == 32'h0000_0000) begin
                                st_q <= ppc_pkg::PPC_DET_DONE;
                            end else begin
                                tmr_q <= tmr_q - 32'h0000_0001;
                            end
                        end
                        ppc_pkg::PPC_DET_DONE: begin
                            st_q <= ppc_pkg::PPC_DET_IDLE;
                        end
                        default: begin
                            st_q <= ppc_pkg::PPC_DET_IDLE;
                        end
                    endcase
                end
            end
            always_ff @(posedge mclk or negedge core_rst_b) begin
                if (!core_rst_b) begin
                    discharge_en[g] <= 1'b0;
                    probe_lo_en[g] <= 1'b0;
                    probe_hi_en[g] <= 1'b0;
                    detect_done[g] <= 1'b0;
                end else begin
                    discharge_en[g] <= (st_q == ppc_pkg::PPC_DET_BACKOFF);
                    probe_lo_en[g] <= (st_q == ppc_pkg::PPC_DET_PROBE_LO);
                    probe_hi_en[g] <= (st_q == ppc_pkg::PPC_DET_PROBE_HI);
                    detect_done[g] <= (st_q == ppc_pkg::PPC_DET_DONE);
                end
            end
        end
    endgenerate

    // classification has no shared resource; every port may run at once
    always_ff @(posedge mclk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            class_active <= `PPC_PORT_ALL_OFF;
        end else begin
            class_active <= class_req & ~on_q;
        end
    end

    // mode strap is a pin: two flops before anything reads it
    always_ff @(posedge mclk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
        end else begin
            strap_s1_q <= auto_strap_grounded;
            strap_s2_q <= strap_s1_q;
        end
    end

    // mode strap loaded on each of the first three cycles after reset, then held; the last load is after the synchroniser has settled
    always_ff @(posedge mclk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            strap_cnt_q <= 2'h0;
            autonomous_en <= 1'b0;
        end else if (strap_cnt_q != `PPC_STRAP_SETTLE) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            autonomous_en <= strap_s2_q;
        end
    end

    // interrupt pin, open drain
    always_ff @(posedge mclk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            int_pin_oe_b <= 1'b1;
            int_pin_out <= 1'b0;
        end else begin
            int_pin_oe_b <= ~(|int_flags);
            int_pin_out <= 1'b0;
        end
    end

    // split serial data lines
    always_ff @(posedge mclk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            sd_s1_q <= 1'b1;
            sd_s2_q <= 1'b1;
            serial_data_in_q <= 1'b1;
            serial_data_out_pin_oe_b <= 1'b1;
            serial_data_out_pin_out <= 1'b0;
        end else begin
            sd_s1_q <= serial_data_in_pin;
            sd_s2_q <= sd_s1_q;
            serial_data_in_q <= sd_s2_q;
            serial_data_out_pin_oe_b <= ~serial_data_drive_low;
            serial_data_out_pin_out <= 1'b0;
        end
    end
endmodule

// *** ppc_top_properties.sv ***
// assertions on the port pin control block ports
module ppc_chk #(
    parameter int NPORT = 8
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic por_b,
    input wire logic reset_pin_b,
    input wire logic [7:0] int_flags,
    input wire logic [NPORT-1:0] port_on_req,
    input wire logic [NPORT-1:0] manual_shutdown,
    input wire logic [NPORT-1:0] overcurrent_timeout,
    input wire logic [NPORT-1:0] fast_overload,
    input wire logic supplies_ok,
    input wire logic [NPORT-1:0] class_req,
    input wire logic serial_data_drive_low,
    input wire logic int_pin_oe_b,
    input wire logic serial_data_out_pin_oe_b,
    input wire logic [NPORT-1:0] port_gate_drive,
    input wire logic [NPORT-1:0] discharge_en,
    input wire logic [NPORT-1:0] probe_lo_en,
    input wire logic [NPORT-1:0] probe_hi_en,
    input wire logic [NPORT-1:0] class_active
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] hi_q;
    logic [5:0] lo_q;
    // settle time after any reset source
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) hi_q <= 6'h00;
        else if (!reset_pin_b || !por_b) hi_q <= 6'h00;
        else if (hi_q != 6'h3F) hi_q <= hi_q + 6'h01;
    end
    // length of the current low on the reset pin
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) lo_q <= 6'h00;
        else if (reset_pin_b) lo_q <= 6'h00;
        else if (lo_q != 6'h3F) lo_q <= lo_q + 6'h01;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b || hi_q != 6'h3F);
    sequence s_ovl;
        fast_overload[0] [*3];
    endsequence
    sequence s_lo_end;
        $fell(probe_lo_en[0]);
    endsequence
    property p_int_low; |int_flags |=> !int_pin_oe_b; endproperty
    property p_int_rel; int_flags == 8'h00 |=> int_pin_oe_b; endproperty
    property p_rst_off;
        disable iff (!rst_b) lo_q == 6'h28 |-> port_gate_drive == '0 && int_pin_oe_b;
    endproperty
    property p_gate_oc; 1 |=> (port_gate_drive & $past(overcurrent_timeout)) == '0; endproperty
    property p_gate_sup; !supplies_ok |=> port_gate_drive == '0; endproperty
    property p_gate_man; 1 |=> (port_gate_drive & $past(manual_shutdown)) == '0; endproperty
    property p_ovl; s_ovl |=> !port_gate_drive[0]; endproperty
    property p_class;
        port_on_req == '0 && port_gate_drive == '0 |=> class_active == $past(class_req);
    endproperty
    property p_probe; s_lo_end |-> ##[0:1] probe_hi_en[0]; endproperty
    property p_disch;
        $rose(discharge_en[0]) |-> (discharge_en[0] && !probe_lo_en[0]) [*8];
    endproperty
    property p_sdo; serial_data_drive_low |=> !serial_data_out_pin_oe_b; endproperty
    a_int_low: assert property (p_int_low) else $error("int pin not low");
    a_int_rel: assert property (p_int_rel) else $error("int pin not released");
    a_rst_off: assert property (p_rst_off) else $error("reset pin left ports on");
    a_gate_oc: assert property (p_gate_oc) else $error("gate on after timeout");
    a_gate_sup: assert property (p_gate_sup) else $error("gate on, supply low");
    a_gate_man: assert property (p_gate_man) else $error("gate on, manual off");
    a_ovl: assert property (p_ovl) else $error("gate on after overload");
    a_class: assert property (p_class) else $error("class not parallel");
    a_probe: assert property (p_probe) else $error("no second probe level");
    a_disch: assert property (p_disch) else $error("backoff cut short");
    a_sdo: assert property (p_sdo) else $error("data out not driven");
endmodule
bind ppc_top ppc_chk #(.NPORT(NPORT)) u_chk (.mclk, .rst_b, .por_b, .reset_pin_b, .int_flags,
    .port_on_req, .manual_shutdown, .overcurrent_timeout, .fast_overload, .supplies_ok,
    .class_req, .serial_data_drive_low, .int_pin_oe_b, .serial_data_out_pin_oe_b,
    .port_gate_drive, .discharge_en, .probe_lo_en, .probe_hi_en, .class_active);

// *** ppc_host.sv ***
// host model: shared serial data line and fast shutdown pulse trains
module ppc_host (
    input wire logic mclk,
    input wire logic dev_oe_b,
    output logic sda,
    output logic fsd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pull_lo = 1'h0;
    initial fsd = 1'h0;
    // data lines tied, pulled up; low if either side pulls
    assign sda = !(pull_lo || !dev_oe_b);
    task put(input logic v);
        @(negedge mclk) pull_lo = !v;
    endtask
    task train(input int n, input int w);
        repeat (n) begin
            @(negedge mclk) fsd = 1'h1;
            repeat (w) @(negedge mclk);
            fsd = 1'h0;
            repeat (w) @(negedge mclk);
        end
    endtask
endmodule

// *** ppc_top_tb.sv ***
// self-checking bench for the port pin control block
module ppc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'h0;
    logic rst_b, por_b, rp_b, fsd, sdl, strap, sup, sdi, int_oe, so_oe, sdq, auto, ipo, spo;
    logic [2:0] sprio;
    logic [23:0] prio;
    logic [7:0] onr, rc, man, oc, ovl, vh, dr, cr, fl, kill, evt;
    logic [7:0] gate, dis, plo, phi, done, cls, offe;
    logic [7:0] q[$];
    int err_total, cmp_count, seed, cyc;
    ppc_top #(.BACKOFF_CYC(50), .PROBE_CYC(20)) dut (.mclk, .rst_b, .por_b,
        .reset_pin_b(rp_b), .fast_shutdown_in(fsd), .shutdown_priority(sprio),
        .port_priority(prio), .port_on_req(onr), .port_reset_cmd(rc), .manual_shutdown(man),
        .overcurrent_timeout(oc), .fast_overload(ovl), .supplies_ok(sup),
        .port_voltage_high(vh), .detect_req(dr), .class_req(cr), .int_flags(fl),
        .auto_strap_grounded(strap), .serial_data_in_pin(sdi), .serial_data_drive_low(sdl),
        .int_pin_oe_b(int_oe), .int_pin_out(ipo), .serial_data_out_pin_oe_b(so_oe),
        .serial_data_out_pin_out(spo), .serial_data_in_q(sdq), .port_gate_drive(gate),
        .discharge_en(dis), .probe_lo_en(plo), .probe_hi_en(phi), .detect_done(done),
        .class_active(cls), .autonomous_en(auto), .port_off_event(offe));
    ppc_host u_host (.mclk, .dev_oe_b(so_oe), .sda(sdi), .fsd);
    initial begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end
    task chk(input string n, input logic [23:0] e, input logic [23:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task cy(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task close_out;
        if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task on_all;
        onr = 8'hFF;
        cy(2);
        onr = 8'h00;
        cy(1);
        chk("gate_on", 24'hFF, 24'(gate));
    endtask
    task det(input int p, input logic h);
        int nd, nl, nh;
        nd = 0; nl = 0; nh = 0;
        vh = 8'h00; vh[p] = h; dr = 8'h00; dr[p] = 1'h1;
        q.push_back(dr);
        cy(1);
        dr = 8'h00;
        repeat (200) begin
            cy(1);
            nd += dis[p]; nl += plo[p]; nh += phi[p];
            if (dis[p]) vh[p] = 1'h0;
        end
        chk("discharge", 24'(h ? 50 : 0), 24'(nd));
        chk("probe_lo", 24'h14, 24'(nl));
        chk("probe_hi", 24'h14, 24'(nh));
    endtask
    task fsd_run(input int n);
        evt = 8'h00;
        u_host.train(n, 30);
        repeat (700) begin
            cy(1);
            evt |= offe;
        end
        chk("gate_fsd", 24'(kill ^ 8'hFF), 24'(gate));
        chk("off_event", 24'(kill), 24'(evt));
    endtask
    always @(negedge mclk) if (done !== 8'h00) begin
        if (q.size() == 0) chk("det_done", 24'h0, 24'(done));
        else chk("det_done", 24'(q.pop_front()), 24'(done));
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            close_out;
        end
    end
    initial begin
        rst_b = 1'h0; por_b = 1'h0; rp_b = 1'h1; sdl = 1'h0; strap = 1'h1; sup = 1'h1;
        sprio = 3'h0; prio = 24'h0; onr = 8'h00; rc = 8'h00; man = 8'h00; oc = 8'h00;
        ovl = 8'h00; vh = 8'h00; dr = 8'h00; cr = 8'h00; fl = 8'h00; seed = 74833;
        cy(2);
        rst_b = 1'h1; por_b = 1'h1;
        cy(40);
        chk("auto", 24'h1, 24'(auto));
        strap = 1'h0;
        for (int i = 0; i < 4; i++) begin
            fl = i[0] ? 8'($random(seed)) | 8'h01 : 8'h00;
            cy(2);
            chk("int_oe", 24'(fl == 8'h00), 24'(int_oe));
        end
        chk("od_out", 24'h0, 24'({ipo, spo}));
        sdl = 1'h1; cy(5);
        chk("sdo_oe", 24'h0, 24'(so_oe));
        chk("sdi_q", 24'h0, 24'(sdq));
        sdl = 1'h0; u_host.put(1'h0); cy(5);
        chk("sdi_q", 24'h0, 24'(sdq));
        u_host.put(1'h1); cy(5);
        chk("sdi_q", 24'h1, 24'(sdq));
        on_all;
        man = 8'($random(seed)); cy(2);
        chk("gate_man", 24'h0, 24'(gate & man));
        man = 8'h00; on_all;
        oc = 8'($random(seed)); cy(2);
        chk("gate_oc", 24'h0, 24'(gate & oc));
        oc = 8'h00; on_all;
        ovl = 8'h01; cy(5);
        chk("gate_ovl", 24'h0, 24'(gate[0]));
        ovl = 8'h00; sup = 1'h0; cy(2);
        chk("gate_sup", 24'h0, 24'(gate));
        sup = 1'h1; rc = 8'hFF; cy(2);
        rc = 8'h00; cr = 8'($random(seed)); cy(2);
        chk("class", 24'(cr), 24'(cls));
        det(0, 1'h1);
        det(5, 1'h0);
        on_all;
        kill = 8'h00;
        u_host.train(1, 10);
        fsd_run(0);
        kill = 8'hFF;
        fsd_run(1);
        on_all;
        sprio = 3'h1; prio = 24'($random(seed));
        for (int i = 0; i < 8; i++) kill[i] = prio[3*i+:3] >= 3'h2;
        fsd_run(2);
        on_all; fl = 8'h5A;
        rp_b = 1'h0; cy(8); rp_b = 1'h1; cy(40);
        chk("gate_rpulse", 24'hFF, 24'(gate));
        rp_b = 1'h0; cy(40);
        chk("gate_rst", 24'h0, 24'(gate));
        chk("int_rst", 24'h1, 24'(int_oe));
        rp_b = 1'h1; cy(40);
        on_all;
        por_b = 1'h0; cy(1); por_b = 1'h1; cy(40);
        chk("gate_por", 24'h0, 24'(gate));
        chk("auto", 24'h0, 24'(auto));
        close_out;
    end
endmodule
